//--- hdl/ssr_spi_regs.v
/*
  serial peripheral data, control and control/status registers with a
  small shift engine, reached over an ahb-lite slave port.
  assumes one clock i_ref_clk, a synchronous active-high reset, and that
  the serial pins are asynchronous to the clock (they are synchronised).
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssr_spi_defs.vh"

module ssr_spi_regs (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire        i_hsel,
  input  wire [7:0]  i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  input  wire        i_sck,
  output reg         o_sck,
  output reg         o_sck_oe,
  input  wire        i_mosi,
  output reg         o_mosi,
  output reg         o_mosi_oe,
  input  wire        i_miso,
  output reg         o_miso,
  output reg         o_miso_oe,
  input  wire        i_ss_n,
  output reg         o_irq
);

  // map a byte address onto a register select
  function [2:0] ssr_sel;
    input [7:0] a;
    begin
      case (a)
        `SSR_ADDR_DATA:     ssr_sel = `SSR_SEL_DATA;
        `SSR_ADDR_CTRL:     ssr_sel = `SSR_SEL_CTRL;
        `SSR_ADDR_CSR:      ssr_sel = `SSR_SEL_CSR;
        `SSR_ADDR_IRQ_STAT: ssr_sel = `SSR_SEL_IST;
        `SSR_ADDR_IRQ_MASK: ssr_sel = `SSR_SEL_IMSK;
        default:            ssr_sel = `SSR_SEL_NONE;
      endcase
    end
  endfunction

  // half serial-clock period in cycles, minus one, per rate code
  function [6:0] ssr_half;
    input [2:0] code;
    begin
      case (code)
        3'h4:    ssr_half = `SSR_HALF_4;
        3'h0:    ssr_half = `SSR_HALF_8;
        3'h1:    ssr_half = `SSR_HALF_16;
        3'h6:    ssr_half = `SSR_HALF_32;
        3'h2:    ssr_half = `SSR_HALF_64;
        default: ssr_half = `SSR_HALF_128;
      endcase
    end
  endfunction

  reg  [7:0] cr_q;          // control register
  reg        sod_q;         // output_disable
  reg        ssm_q;         // select_management
  reg        ssi_q;         // internal_select_level
  reg        transfer_done_flag_q;        // transfer_done_flag
  reg        write_collision_flag_q;        // write_collision_flag
  reg        ovr_q;         // overrun_flag
  reg        mode_fault_flag_q;        // mode_fault_flag
  reg        csr_seen_q;    // status read seen, awaiting data access
  reg        mode_fault_flag_arm_q;    // status read while fault set
  reg  [7:0] rxbuf_q;       // receive buffer
  reg  [7:0] shreg_q;       // shift register
  reg        rbit_q;        // bit sampled, waiting for its shift edge
  reg  [4:0] edge_q;        // serial clock edges done in this byte
  reg  [6:0] div_q;         // master half-period counter
  reg        mbusy_q;       // master transfer running
  reg        sck_q;         // master clock level
  reg  [2:0] ist_q;         // sticky interrupt status
  reg  [2:0] imask_q;       // interrupt mask
  reg        wr_pend_q;     // write data phase pending
  reg  [2:0] wsel_q;        // register of that write
  wire [3:0] pin_raw = {i_ss_n, i_miso, i_mosi, i_sck}; // async pins
  wire [3:0] sync2_w;       // second synchroniser stage, per pin
  reg        sck_old_q;     // previous synchronised clock level

  wire s_sck  = sync2_w[0];
  wire s_mosi = sync2_w[1];
  wire s_miso = sync2_w[2];
  wire s_ss_n = sync2_w[3];

  // two flops on every pin input before anything reads it
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg s1_q; // first stage, read only by the second
      reg s2_q; // second stage, the only one logic may read
      // each pin owns its flops, so no vector has two drivers
      always @(posedge i_ref_clk) begin
        if (i_rst) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
        end
      end
      assign sync2_w[gi] = s2_q;
    end
  endgenerate

  // bus decode: reads act in the address phase, writes in the data phase
  wire [2:0] asel  = ssr_sel(i_haddr);
  wire       rd_ok = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
  wire       rd_dr = rd_ok & (asel == `SSR_SEL_DATA);
  wire       rd_cs = rd_ok & (asel == `SSR_SEL_CSR);
  wire       rd_is = rd_ok & (asel == `SSR_SEL_IST);
  wire       wr_dr = wr_pend_q & (wsel_q == `SSR_SEL_DATA);
  wire       wr_cr = wr_pend_q & (wsel_q == `SSR_SEL_CTRL);
  wire       wr_cs = wr_pend_q & (wsel_q == `SSR_SEL_CSR);
  wire       wr_im = wr_pend_q & (wsel_q == `SSR_SEL_IMSK);
  wire [7:0] wbyte = i_hwdata[7:0];

  wire enable = cr_q[`SSR_CR_ENABLE];
  wire master = cr_q[`SSR_CR_MASTER];
  wire cpha   = cr_q[`SSR_CR_CPHA];
  wire cpol   = cr_q[`SSR_CR_CPOL];

  // internal select level from pin or software bit
  wire ss_int   = ssm_q ? ssi_q : s_ss_n;
  wire selected = ~ss_int;
  wire fault    = master & ~ss_int;

  // flag sequences
  wire dr_access = rd_dr | wr_dr;
  wire dr_block  = transfer_done_flag_q & ~csr_seen_q;
  wire xbusy     = mbusy_q | (edge_q != 5'h00);
  wire write_collision_flag_set  = wr_dr & ~dr_block & xbusy;
  wire load      = wr_dr & ~dr_block & ~xbusy & ~fault;
  wire start     = load & enable & master;
  wire transfer_done_flag_clr  = csr_seen_q & dr_access;
  wire write_collision_flag_clr  = csr_seen_q & rd_dr;
  wire mode_fault_flag_clr  = mode_fault_flag_arm_q & wr_cr;

  // serial clock edge events, from the divider or from the pin
  wire mtick  = mbusy_q & (div_q == 7'h00);
  wire sedge  = enable & ~master & selected & (s_sck != sck_old_q);
  wire evt    = master ? mtick : sedge;
  wire [4:0] k = edge_q + 5'h01;
  wire samp   = k[0] ^ cpha;
  wire din    = master ? s_miso : s_mosi;
  wire done   = evt & (k == `SSR_LAST_EDGE);
  wire [7:0] shin = {shreg_q[6:0], samp ? din : rbit_q};
  wire ovr_set = done & transfer_done_flag_q;

  // shift engine: cpha picks which edge samples and which shifts
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      shreg_q   <= 8'h00;
      rbit_q    <= 1'b0;
      edge_q    <= 5'h00;
      div_q     <= 7'h00;
      mbusy_q   <= 1'b0;
      sck_q     <= 1'b0;
      // matches the synchroniser's reset level: no false edge after reset
      sck_old_q <= 1'b1;
      rxbuf_q   <= 8'h00;
    end else begin
      sck_old_q <= s_sck;
      if (load) begin
        // byte goes straight into the shifter, no holding register
        shreg_q <= wbyte;
        edge_q  <= 5'h00;
      end else if (done) begin
        shreg_q <= shin;
        edge_q  <= 5'h00;
        // overrun keeps the unread byte; the new one is lost
        if (!transfer_done_flag_q) begin
          rxbuf_q <= shin;
        end
      end else if (evt) begin
        edge_q <= k;
        if (samp) begin
          rbit_q <= din;
        end else if (k != 5'h01) begin
          shreg_q <= shin;
        end
      end else if (!master && !selected) begin
        // deselect aborts a partial slave byte
        edge_q <= 5'h00;
      end
      // master divider and clock
      if (fault || (done && master)) begin
        mbusy_q <= 1'b0;
        sck_q   <= cpol;
      end else if (start) begin
        mbusy_q <= 1'b1;
        div_q   <= ssr_half({cr_q[`SSR_CR_RATE2], cr_q[1:0]});
        sck_q   <= cpol;
      end else if (mtick) begin
        div_q   <= ssr_half({cr_q[`SSR_CR_RATE2], cr_q[1:0]});
        sck_q   <= ~sck_q;
      end else if (mbusy_q) begin
        div_q   <= div_q - 7'h01;
      end else begin
        sck_q   <= cpol;
      end
    end
  end

  // status flags; a hardware set always wins over a software clear
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      transfer_done_flag_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      ovr_q      <= 1'b0;
      mode_fault_flag_q     <= 1'b0;
      csr_seen_q <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else begin
      if (done) begin
        transfer_done_flag_q <= 1'b1;
      end else if (transfer_done_flag_clr) begin
        transfer_done_flag_q <= 1'b0;
      end
      if (write_collision_flag_set) begin
        write_collision_flag_q <= 1'b1;
      end else if (write_collision_flag_clr) begin
        write_collision_flag_q <= 1'b0;
      end
      if (ovr_set) begin
        ovr_q <= 1'b1;
      end else if (rd_cs) begin
        ovr_q <= 1'b0;
      end
      if (fault) begin
        mode_fault_flag_q <= 1'b1;
      end else if (mode_fault_flag_clr) begin
        mode_fault_flag_q <= 1'b0;
      end
      // sequence trackers
      if (rd_cs) begin
        csr_seen_q <= 1'b1;
      end else if (dr_access) begin
        csr_seen_q <= 1'b0;
      end
      if (rd_cs) begin
        mode_fault_flag_arm_q <= mode_fault_flag_q;
      end else if (wr_cr) begin
        mode_fault_flag_arm_q <= 1'b0;
      end
    end
  end

  // software-written registers
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      cr_q    <= `SSR_CR_RESET;
      sod_q   <= 1'b0;
      ssm_q   <= 1'b0;
      ssi_q   <= 1'b0;
      imask_q <= 3'h0;
    end else begin
      if (wr_cr) begin
        cr_q <= wbyte;
      end
      if (fault) begin
        // fault drops enable and master even over a same-cycle write
        cr_q[`SSR_CR_ENABLE] <= 1'b0;
        cr_q[`SSR_CR_MASTER] <= 1'b0;
      end
      if (wr_cs) begin
        // flag bits and bit 3 are read only
        sod_q <= wbyte[2];
        ssm_q <= wbyte[1];
        ssi_q <= wbyte[0];
      end
      if (wr_im) begin
        imask_q <= wbyte[2:0];
      end
    end
  end

  // sticky interrupt status, cleared by reading it
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      ist_q <= 3'h0;
    end else begin
      ist_q <= (rd_is ? 3'h0 : ist_q) | {fault, ovr_set, done};
    end
  end

  // bus slave: zero wait states, read data registered in address phase
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_pend_q   <= 1'b0;
      wsel_q      <= `SSR_SEL_NONE;
      o_hrdata    <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend_q   <= i_hsel & i_htrans[1] & i_hready & i_hwrite;
      wsel_q      <= asel;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (rd_ok) begin
        case (asel)
          `SSR_SEL_DATA: o_hrdata <= {24'h000000, rxbuf_q};
          `SSR_SEL_CTRL: o_hrdata <= {24'h000000, cr_q};
          `SSR_SEL_CSR:  o_hrdata <= {24'h000000, transfer_done_flag_q, write_collision_flag_q, ovr_q,
                                      mode_fault_flag_q, 1'b0, sod_q, ssm_q,
                                      ssi_q};
          `SSR_SEL_IST:  o_hrdata <= {29'h0000000, ist_q};
          `SSR_SEL_IMSK: o_hrdata <= {29'h0000000, imask_q};
          default:       o_hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // pins and interrupt, all from flops
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sck     <= 1'b0;
      o_sck_oe  <= 1'b0;
      o_mosi    <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
      o_irq     <= 1'b0;
    end else begin
      o_sck     <= sck_q;
      o_sck_oe  <= enable & master;
      o_mosi    <= shreg_q[7];
      o_miso    <= shreg_q[7];
      o_mosi_oe <= enable & master & ~sod_q;
      o_miso_oe <= enable & ~master & selected & ~sod_q;
      o_irq     <= cr_q[`SSR_CR_IRQ_EN] & |(ist_q & imask_q);
    end
  end

endmodule
`default_nettype wire

//--- hdl/ssr_spi_defs.vh
/*
  constants of the serial status/data register block: register indexes,
  bus byte addresses, field positions, reset values and divider codes.
  assumes it is included by bare name from the block's one design file.
*/
`ifndef SSR_SPI_DEFS_VH
`define SSR_SPI_DEFS_VH

// register indexes; byte address is four times the index
`define SSR_IDX_DATA     6'h31
`define SSR_IDX_CTRL     6'h32
`define SSR_IDX_CSR      6'h33
`define SSR_IDX_IRQ_STAT 6'h34
`define SSR_IDX_IRQ_MASK 6'h35
`define SSR_ADDR_DATA     {`SSR_IDX_DATA, 2'b00}
`define SSR_ADDR_CTRL     {`SSR_IDX_CTRL, 2'b00}
`define SSR_ADDR_CSR      {`SSR_IDX_CSR, 2'b00}
`define SSR_ADDR_IRQ_STAT {`SSR_IDX_IRQ_STAT, 2'b00}
`define SSR_ADDR_IRQ_MASK {`SSR_IDX_IRQ_MASK, 2'b00}

// decoded register selects
`define SSR_SEL_NONE 3'h0
`define SSR_SEL_DATA 3'h1
`define SSR_SEL_CTRL 3'h2
`define SSR_SEL_CSR  3'h3
`define SSR_SEL_IST  3'h4
`define SSR_SEL_IMSK 3'h5

// control register fields
`define SSR_CR_IRQ_EN  7
`define SSR_CR_ENABLE  6
`define SSR_CR_RATE2   5
`define SSR_CR_MASTER  4
`define SSR_CR_CPOL    3
`define SSR_CR_CPHA    2
`define SSR_CR_RESET   8'h00
`define SSR_CSR_RESET  8'h00

// interrupt status/mask bits
`define SSR_IRQ_DONE  0
`define SSR_IRQ_OVR   1
`define SSR_IRQ_FAULT 2

// edges in one byte and half-period counts per rate code
`define SSR_LAST_EDGE 5'h10
`define SSR_HALF_4    7'h01
`define SSR_HALF_8    7'h03
`define SSR_HALF_16   7'h07
`define SSR_HALF_32   7'h0F
`define SSR_HALF_64   7'h1F
`define SSR_HALF_128  7'h3F

`endif

//--- bench/ssr_spi_checker.sv
/*
  port-level checks on the serial register block.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_spi_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_hsel,
  input wire logic [7:0]  i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_sck_oe,
  input wire logic        o_mosi_oe,
  input wire logic        o_miso_oe,
  input wire logic        o_irq
);
  wire rd_take; // read taken at this edge
  assign rd_take = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_ready; o_hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state");
  property p_resp; !o_hresp; endproperty
  a_resp: assert property (p_resp) else $error("error resp");
  property p_hi; o_hrdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper data");
  property p_unmap; rd_take && i_haddr == 8'h00 |=> o_hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_rsvd; rd_take && i_haddr == 8'hCC |=> !o_hrdata[3]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit");
  // data out only drives while the master clock drives
  property p_mosi; o_mosi_oe |-> o_sck_oe; endproperty
  a_mosi: assert property (p_mosi) else $error("mosi oe");
  property p_miso; o_miso_oe |-> !o_sck_oe && !o_mosi_oe; endproperty
  a_miso: assert property (p_miso) else $error("miso oe");
  // enable resets to zero, so pins start released
  property p_rst;
    $fell(i_rst) |-> !o_irq && !o_sck_oe && !o_mosi_oe && !o_miso_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outs");
endmodule
bind ssr_spi_regs ssr_spi_checker u_chk (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_sck_oe(o_sck_oe),
  .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe), .o_irq(o_irq));
`default_nettype wire

//--- bench/ssr_spi_peer.sv
/*
  behavioural far-end serial slave, clock mode 0, msb first.
  assumes the master clock idles low between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_spi_peer (
  input  wire logic       i_sck,  // master clock, gated by its enable
  input  wire logic       i_mosi, // master data
  input  wire logic       i_load, // rising edge loads reply byte
  input  wire logic [7:0] i_tx,   // reply byte
  output var  logic       o_miso, // reply data
  output var  logic [7:0] o_rx,   // last whole byte received
  output var  int         o_cnt   // whole bytes received
);
  logic [7:0] tx_sh = 8'h00; // reply shifter
  logic [7:0] rx_sh = 8'h00; // receive shifter
  int         bits  = 0;     // bits in this byte
  initial o_cnt = 0;
  // capture on rising edges, where the master samples too
  always @(posedge i_sck) begin
    rx_sh = {rx_sh[6:0], i_mosi};
    bits = bits + 1;
    if (bits == 8) begin
      bits = 0;
      o_rx = rx_sh;
      o_cnt = o_cnt + 1;
    end
  end
  // inverted tail: stale data after a frame never looks valid
  always @(negedge i_sck) tx_sh <= {tx_sh[6:0], ~tx_sh[0]};
  always @(posedge i_load) tx_sh <= i_tx;
  always @* o_miso = tx_sh[7];
endmodule
`default_nettype wire

//--- bench/testbench.sv
/*
  self-checking bench: register block as master against a peer model, then as slave to the bench.
  assumes design, checker and peer are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, load = 0, ss_n = 1;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00, rd, tx = 8'h00, b, sr;
  logic        s_sck = 0, s_mosi = 0; // far-end master pins, slave mode
  wire         so, so_oe;             // slave data out and its enable
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  sent_q[$], peer_q[$]; // bytes sent and replies loaded
  wire  [31:0] hrdata;
  wire         hrdy, sck, sck_oe, mosi, mosi_oe, miso, irq;
  wire  [7:0]  rx;
  int          cnt, bad_count = 0, n_compared = 0, i;
  initial forever #5 clk = ~clk;
  ssr_spi_regs u_dut (.i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(), .i_sck(s_sck), .o_sck(sck),
    .o_sck_oe(sck_oe), .i_mosi(s_mosi), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
    .i_miso(miso), .o_miso(so), .o_miso_oe(so_oe), .i_ss_n(ss_n),
    .o_irq(irq));
  ssr_spi_peer u_peer (.i_sck(sck & sck_oe), .i_mosi(mosi & mosi_oe),
    .i_load(load), .i_tx(tx), .o_miso(miso), .o_rx(rx), .o_cnt(cnt));
  // one single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    rd = hrdata[7:0];
  endtask
  // load a random reply into the peer, then write the data register
  task automatic send(input logic [7:0] d);
    tx <= 8'($urandom);
    load <= 1;
    @(posedge clk);
    load <= 0;
    peer_q.push_back(tx);
    sent_q.push_back(d);
    bus(1, 8'hC4, d);
  endtask
  // far-end master, mode 0, 80 ns clock; miso taken late in the high half
  task automatic mxfer(input logic [7:0] m, output logic [7:0] r);
    int j;
    for (j = 7; j >= 0; j--) begin
      s_mosi <= m[j];
      repeat (4) @(posedge clk);
      s_sck <= 1;
      repeat (4) @(posedge clk);
      r[j] = so & so_oe;
      s_sck <= 0;
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_irq;
    i = 0;
    while (irq !== 1'b1 && i < 2000) begin
      @(posedge clk);
      i++;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // a hung handshake lands here instead of running forever
  initial begin
    #200us;
    bad_count++;
    conclude();
  end
  initial begin
    i = $urandom(39266);
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h00, rd)
    bus(0, 8'hC8, 0);
    `CHK("ctrl", 8'h00, rd)
    bus(0, 8'h00, 0);
    `CHK("unmapped", 8'h00, rd)
    bus(1, 8'hD4, 8'h07);
    bus(1, 8'hC8, 8'hD0);
    b = 8'($urandom);
    send(b);
    bus(1, 8'hC4, ~b); // lands mid-byte
    wait_irq();
    `CHK("irq", 1'b1, irq)
    `CHK("rx", sent_q[0], rx)
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'hC0, rd)
    bus(0, 8'hC4, 0);
    `CHK("data", peer_q[0], rd)
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h00, rd)
    bus(0, 8'hD0, 0);
    `CHK("irq stat", 8'h01, rd)
    send(8'($urandom));
    wait_irq();
    `CHK("rx", sent_q[1], rx)
    bus(1, 8'hC4, 8'h5A); // no status read yet, so refused
    repeat (300) @(posedge clk);
    `CHK("bytes", 2, cnt)
    bus(1, 8'hCC, 8'h04);
    bus(0, 8'hD0, 0);
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h84, rd)
    send(8'($urandom));
    repeat (8) @(posedge clk);
    `CHK("oe", 2'b10, {sck_oe, mosi_oe})
    wait_irq();
    bus(1, 8'hCC, 8'h03);
    ss_n <= 0;
    repeat (10) @(posedge clk);
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h03, rd & 8'h1F)
    bus(1, 8'hCC, 8'h02);
    repeat (4) @(posedge clk);
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h12, rd & 8'h1F)
    bus(0, 8'hC8, 0);
    `CHK("ctrl", 8'h80, rd)
    `CHK("irq", 1'b1, irq)
    bus(1, 8'hCC, 8'h03);
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h13, rd & 8'h1F)
    bus(1, 8'hC8, 8'hD0);
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h03, rd & 8'h1F)
    ss_n <= 1;
    bus(1, 8'hD4, 8'h00);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    bus(0, 8'hD0, 0);
    `CHK("irq stat", 8'h05, rd)
    bus(0, 8'hD0, 0);
    `CHK("irq stat", 8'h00, rd)
    // slave mode: the bench plays the far-end master on the pins
    bus(1, 8'hD4, 8'h07);
    bus(1, 8'hC8, 8'hC0);
    bus(1, 8'hCC, 8'h02);
    bus(0, 8'hCC, 0);
    b = 8'($urandom);
    bus(1, 8'hC4, b);
    mxfer(8'h3C, sr);
    `CHK("slave out", b, sr)
    `CHK("miso oe", 1'b1, so_oe)
    wait_irq();
    `CHK("irq", 1'b1, irq)
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h82, rd)
    bus(0, 8'hC4, 0);
    `CHK("data", 8'h3C, rd)
    mxfer(8'hA5, sr);
    `CHK("echo", 8'h3C, sr)
    mxfer(8'h96, sr);
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'hA2, rd)
    bus(0, 8'hCC, 0);
    `CHK("csr", 8'h82, rd)
    bus(0, 8'hC4, 0);
    `CHK("data", 8'hA5, rd)
    bus(0, 8'hD0, 0);
    `CHK("irq stat", 8'h03, rd)
    conclude();
  end
endmodule
`default_nettype wire
